// ==== logic/vsi_slave_image.sv ====
// Functional notes
// - data strobe filter bit filters both data strobes.
// - address strobe filter bit filters the address strobe.
// - ack release filter select: zero slow robust, one fast weak.
// - master strobe high time between block beats: default or shorter.
// - master read release delay field: default, faster or none.
// - posted write strobe-to-ack time: default or shorter.
// - prefetched read strobe-to-ack time: default or shorter.
// - image answers only while its enable bit is one.
// - posted write enable acks writes at once, forwards later.
// - prefetch enable fetches read data ahead of demand.
// - posted and prefetch enables ignored unless PCI memory space.
// - program/data field selects accepted modifier classes, reset both.
// - privilege field selects accepted privilege classes, reset both.
// - space field selects A16, A24, A32, user1 or user2.
// - wide enable permits 64-bit PCI transfers for this image.
// - lock enable holds PCI lock through read-modify-write cycle.
// - PCI space field directs cycles to memory, I/O or config.
// - claim when base <= address < bound.
// - base and bound hold address bits 31:12, cleared at reset.
// - no response unless PCI master enable is set.
// - only memory space cycles are decoupled.
// - user spaces map to modifier codes 0x10 to 0x1F.
//
// Our own choice: register access over AHB-Lite.
module vsi_slave_image
   import vsi_pkg::*;
(
   input  wire logic        clk,                     // 200 MHz clock
   input  wire logic        rst,                     // synchronous reset, high
   input  wire logic        hsel,                    // AHB slave select
   input  wire logic [31:0] haddr,                   // AHB address
   input  wire logic [1:0]  htrans,                  // AHB transfer type
   input  wire logic        hwrite,                  // AHB write
   input  wire logic [2:0]  hsize,                   // AHB size
   input  wire logic [31:0] hwdata,                  // AHB write data
   input  wire logic        hready,                  // AHB bus ready
   output logic [31:0]      hrdata,                  // AHB read data
   output logic             hreadyout,               // AHB slave ready
   output logic             hresp,                   // AHB response
   input  wire logic        vmeAsN,                  // VME address strobe pin
   input  wire logic        vmeDs0N,                 // VME data strobe 0 pin
   input  wire logic        vmeDs1N,                 // VME data strobe 1 pin
   input  wire logic        vmeWriteN,               // VME write, low for write
   input  wire logic [5:0]  vmeAm,                   // VME address modifier
   input  wire logic [31:1] vmeAddr,                 // VME address lines
   input  wire logic        vmeDtackIn,              // VME ack pin level
   output logic             vmeDtackOut,             // VME ack drive level
   output logic             vmeDtackOe,              // VME ack output enable
   output logic             masterDtackN,            // filtered ack for master
   output logic [3:0]       masterStrobeHighCycles,  // master strobe high time
   output logic [3:0]       masterReadReleaseCycles, // master release delay
   input  wire logic        pciMasterEnable,         // PCI bus master enable
   input  wire logic [3:0]  user1Am,                 // user code 1 low nibble
   input  wire logic [3:0]  user2Am,                 // user code 2 low nibble
   output logic             pciReq,                  // forwarded cycle pending
   output logic             pciWrite,                // forwarded cycle is write
   output logic [31:0]      pciAddr,                 // forwarded address
   output logic [1:0]       pciSpace,                // PCI target space
   output logic             pciWide,                 // 64-bit permitted
   output logic             pciLock,                 // PCI lock held
   output logic             pciPosted,               // write was posted
   output logic             pciPrefetch,             // read may prefetch
   input  wire logic        pciAck                   // PCI side completed
);
   typedef enum logic [2:0] {S_IDLE, S_ADDR, S_WAIT, S_DELAY, S_ACK, S_MISS} vsi_state_t;

   vsi_state_t  state_q;
   logic [31:0] tuning_q;
   logic [31:0] control_q;
   logic [19:0] base_q;
   logic [19:0] bound_q;
   logic        wrPend_q;
   logic [11:0] wrAddr_q;
   logic [31:0] rdData;
   logic        asN;
   logic        ds0N;
   logic        ds1N;
   logic [31:1] capAddr_q;
   logic [5:0]  capAm_q;
   logic        capWriteN_q;
   logic [3:0]  timer_q;
   logic        hit;
   logic        memSpace;
   logic        postOk;
   logic        preOk;
   logic        dsLow;

   function automatic logic [31:0] readReg(input logic [11:0] a);
      case (a)
         TUNING_ADDR:  readReg = tuning_q;
         CONTROL_ADDR: readReg = control_q;
         BASE_ADDR:    readReg = {base_q, 12'h000};
         BOUND_ADDR:   readReg = {bound_q, 12'h000};
         default:      readReg = 32'h0000_0000;
      endcase
   endfunction

   // modifier class check
   function automatic logic amMatch(input logic [5:0] am, input logic [2:0] sp,
                                    input logic [1:0] program_data_class, input logic [1:0] priv,
                                    input logic [3:0] u1, input logic [3:0] u2);
      logic classOk;
      logic privOk;
      classOk = (am[1:0] == 2'h1 && program_data_class[0]) || (am[1:0] == 2'h2 && program_data_class[1]);
      privOk  = am[2] ? priv[1] : priv[0];
      case (sp)
         SPACE_A16:   amMatch = am[5:3] == 3'h5 && am[1:0] == 2'h1 && privOk;
         SPACE_A24:   amMatch = am[5:3] == 3'h7 && classOk && privOk;
         SPACE_A32:   amMatch = am[5:3] == 3'h1 && classOk && privOk;
         // user codes live only in 0x10 to 0x1F
         SPACE_USER1: amMatch = am[5:4] == 2'h1 && am[3:0] == u1;
         SPACE_USER2: amMatch = am[5:4] == 2'h1 && am[3:0] == u2;
         default:     amMatch = 1'b0;
      endcase
   endfunction

   assign rdData = readReg(haddr[11:0]);
   // zero wait states, read data set in address phase
   always_ff @(posedge clk) begin
      if (rst) begin
         wrPend_q  <= 1'b0;
         wrAddr_q  <= 12'h000;
         hrdata    <= 32'h0000_0000;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
         wrPend_q  <= hsel && hready && htrans[1] && hwrite;
         wrAddr_q  <= haddr[11:0];
         if (hsel && hready && htrans[1] && !hwrite)
            hrdata <= rdData;
         else
            hrdata <= 32'h0000_0000;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         tuning_q <= 32'h0000_0000;
      end else if (wrPend_q && wrAddr_q == TUNING_ADDR) begin
         // reserved bits read zero
         tuning_q <= '0;
         tuning_q[DS_FILT_BIT]      <= hwdata[DS_FILT_BIT];
         tuning_q[AS_FILT_BIT]      <= hwdata[AS_FILT_BIT];
         tuning_q[ACK_FILT_BIT]     <= hwdata[ACK_FILT_BIT];
         tuning_q[STROBE_HIGH_BIT]  <= hwdata[STROBE_HIGH_BIT];
         tuning_q[READ_REL_LSB+:2]  <= hwdata[READ_REL_LSB+:2];
         tuning_q[POSTED_ACK_BIT]   <= hwdata[POSTED_ACK_BIT];
         tuning_q[PREFETCH_ACK_BIT] <= hwdata[PREFETCH_ACK_BIT];
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         control_q                <= 32'h0000_0000;
         control_q[PGM_LSB+:2]    <= PGM_RESET;
         control_q[PRIV_LSB+:2]   <= PRIV_RESET;
      end else if (wrPend_q && wrAddr_q == CONTROL_ADDR) begin
         control_q                <= '0;
         control_q[EN_BIT]        <= hwdata[EN_BIT];
         control_q[POSTED_WRITE_ENABLE_BIT]      <= hwdata[POSTED_WRITE_ENABLE_BIT];
         control_q[PREFETCH_READ_ENABLE_BIT]      <= hwdata[PREFETCH_READ_ENABLE_BIT];
         control_q[PGM_LSB+:2]    <= hwdata[PGM_LSB+:2];
         control_q[PRIV_LSB+:2]   <= hwdata[PRIV_LSB+:2];
         control_q[SPACE_LSB+:3]  <= hwdata[SPACE_LSB+:3];
         control_q[WIDE_BIT]      <= hwdata[WIDE_BIT];
         control_q[LOCK_BIT]      <= hwdata[LOCK_BIT];
         control_q[PCI_LSB+:2]    <= hwdata[PCI_LSB+:2];
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         base_q  <= 20'h00000;
         bound_q <= 20'h00000;
      end else if (wrPend_q) begin
         if (wrAddr_q == BASE_ADDR)
            base_q <= hwdata[31:WIN_LSB];
         if (wrAddr_q == BOUND_ADDR)
            bound_q <= hwdata[31:WIN_LSB];
      end
   end

   vsi_strobe_filter asFilt (
      .clk     (clk),
      .rst     (rst),
      .pinN    (vmeAsN),
      .filtEn  (tuning_q[AS_FILT_BIT]),
      .longSel (1'b1),
      .outN    (asN)
   );
   // both data strobes share one enable
   vsi_strobe_filter ds0Filt (
      .clk     (clk),
      .rst     (rst),
      .pinN    (vmeDs0N),
      .filtEn  (tuning_q[DS_FILT_BIT]),
      .longSel (1'b1),
      .outN    (ds0N)
   );
   vsi_strobe_filter ds1Filt (
      .clk     (clk),
      .rst     (rst),
      .pinN    (vmeDs1N),
      .filtEn  (tuning_q[DS_FILT_BIT]),
      .longSel (1'b1),
      .outN    (ds1N)
   );
   vsi_strobe_filter ackFilt (
      .clk     (clk),
      .rst     (rst),
      .pinN    (vmeDtackIn),
      .filtEn  (1'b1),
      .longSel (!tuning_q[ACK_FILT_BIT]),
      .outN    (masterDtackN)
   );
   always_ff @(posedge clk) begin
      if (rst) begin
         masterStrobeHighCycles  <= 4'(T11_DEFAULT_CYC);
         masterReadReleaseCycles <= 4'(T27_DEFAULT_CYC);
      end else begin
         masterStrobeHighCycles <= tuning_q[STROBE_HIGH_BIT] ? 4'(T11_FAST_CYC) : 4'(T11_DEFAULT_CYC);
         case (tuning_q[READ_REL_LSB+:2])
            REL_FASTER: masterReadReleaseCycles <= 4'(T27_FAST_CYC);
            REL_NONE:   masterReadReleaseCycles <= 4'h0;
            default:    masterReadReleaseCycles <= 4'(T27_DEFAULT_CYC);
         endcase
      end
   end
   assign dsLow    = !ds0N || !ds1N;
   assign memSpace = control_q[PCI_LSB+:2] == PCI_MEM;
   assign postOk   = memSpace && control_q[POSTED_WRITE_ENABLE_BIT];
   assign preOk    = memSpace && control_q[PREFETCH_READ_ENABLE_BIT];
   assign hit = control_q[EN_BIT] && pciMasterEnable
                && amMatch(capAm_q, control_q[SPACE_LSB+:3], control_q[PGM_LSB+:2],
                           control_q[PRIV_LSB+:2], user1Am, user2Am)
                && capAddr_q[31:WIN_LSB] >= base_q && capAddr_q[31:WIN_LSB] < bound_q;
   // address and modifier captured at cleaned strobe fall, write level while in S_ADDR
   always_ff @(posedge clk) begin
      if (rst) begin
         capAddr_q   <= 31'h0000_0000;
         capAm_q     <= 6'h00;
         capWriteN_q <= 1'b1;
      end else begin
         if (state_q == S_IDLE && !asN) begin
            capAddr_q <= vmeAddr;
            capAm_q   <= vmeAm;
         end
         if (state_q == S_ADDR)
            capWriteN_q <= vmeWriteN;
      end
   end

   // slave cycle sequencer
   always_ff @(posedge clk) begin
      if (rst) begin
         state_q <= S_IDLE;
         timer_q <= 4'h0;
      end else begin
         case (state_q)
            S_IDLE: begin
               if (!asN)
                  state_q <= S_ADDR;
            end
            S_ADDR: begin
               if (asN) begin
                  state_q <= S_IDLE;
               end else if (dsLow && !pciReq) begin
                  if (!hit) begin
                     state_q <= S_MISS;
                  end else if (!vmeWriteN && postOk) begin
                     state_q <= S_DELAY;
                     timer_q <= tuning_q[POSTED_ACK_BIT] ? 4'(T28_FAST_CYC) : 4'(T28_DEFAULT_CYC);
                  end else begin
                     state_q <= S_WAIT;
                  end
               end
            end
            S_WAIT: begin
               if (pciAck) begin
                  state_q <= S_DELAY;
                  if (capWriteN_q && preOk)
                     timer_q <= tuning_q[PREFETCH_ACK_BIT] ? 4'(T28_FAST_CYC) : 4'(T28_DEFAULT_CYC);
                  else
                     timer_q <= 4'h1;
               end
            end
            S_DELAY: begin
               if (timer_q <= 4'h1)
                  state_q <= S_ACK;
               timer_q <= timer_q - 4'h1;
            end
            S_ACK: begin
               if (!dsLow)
                  state_q <= asN ? S_IDLE : S_ADDR;
            end
            S_MISS: begin
               if (asN)
                  state_q <= S_IDLE;
            end
            default: state_q <= S_IDLE;
         endcase
      end
   end

   // open drain, low only while acking
   always_ff @(posedge clk) begin
      if (rst) begin
         vmeDtackOut <= 1'b0;
         vmeDtackOe  <= 1'b0;
      end else begin
         vmeDtackOut <= 1'b0;
         vmeDtackOe  <= state_q == S_ACK && dsLow;
      end
   end

   // held until the PCI side acks
   always_ff @(posedge clk) begin
      if (rst) begin
         pciReq      <= 1'b0;
         pciWrite    <= 1'b0;
         pciAddr     <= 32'h0000_0000;
         pciSpace    <= PCI_MEM;
         pciWide     <= 1'b0;
         pciPosted   <= 1'b0;
         pciPrefetch <= 1'b0;
      end else if (state_q == S_ADDR && !asN && dsLow && !pciReq && hit) begin
         pciReq      <= 1'b1;
         pciWrite    <= !vmeWriteN;
         pciAddr     <= {capAddr_q, 1'b0};
         pciSpace    <= control_q[PCI_LSB+:2];
         pciWide     <= control_q[WIDE_BIT];
         pciPosted   <= !vmeWriteN && postOk;
         pciPrefetch <= vmeWriteN && preOk;
      end else if (pciAck) begin
         pciReq <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (rst)
         pciLock <= 1'b0;
      else if (asN)
         pciLock <= 1'b0;
      else if (state_q == S_ADDR && dsLow && !pciReq && hit && control_q[LOCK_BIT])
         pciLock <= 1'b1;
   end
endmodule

// ==== logic/vsi_pkg.sv ====
package vsi_pkg;
   // register byte addresses
   localparam logic [11:0] TUNING_ADDR  = 12'h4FC;
   localparam logic [11:0] CONTROL_ADDR = 12'hF00;
   localparam logic [11:0] BASE_ADDR    = 12'hF04;
   localparam logic [11:0] BOUND_ADDR   = 12'hF08;

   // timing tuning fields
   localparam int DS_FILT_BIT      = 14;
   localparam int AS_FILT_BIT      = 13;
   localparam int ACK_FILT_BIT     = 12;
   localparam int STROBE_HIGH_BIT  = 10;
   localparam int READ_REL_LSB     = 8;
   localparam int POSTED_ACK_BIT   = 2;
   localparam int PREFETCH_ACK_BIT = 0;

   // image control fields
   localparam int EN_BIT    = 31;
   localparam int POSTED_WRITE_ENABLE_BIT  = 30;
   localparam int PREFETCH_READ_ENABLE_BIT  = 29;
   localparam int PGM_LSB   = 22;
   localparam int PRIV_LSB  = 20;
   localparam int SPACE_LSB = 16;
   localparam int WIDE_BIT  = 7;
   localparam int LOCK_BIT  = 6;
   localparam int PCI_LSB   = 0;
   localparam int WIN_LSB   = 12;

   // values after reset
   localparam logic [1:0] PGM_RESET  = 2'h3;
   localparam logic [1:0] PRIV_RESET = 2'h3;

   // encodings
   localparam logic [2:0] SPACE_A16   = 3'h0;
   localparam logic [2:0] SPACE_A24   = 3'h1;
   localparam logic [2:0] SPACE_A32   = 3'h2;
   localparam logic [2:0] SPACE_USER1 = 3'h6;
   localparam logic [2:0] SPACE_USER2 = 3'h7;
   localparam logic [1:0] PCI_MEM     = 2'h0;
   localparam logic [1:0] PCI_IO      = 2'h1;
   localparam logic [1:0] PCI_CFG     = 2'h2;
   localparam logic [1:0] REL_DEFAULT = 2'h0;
   localparam logic [1:0] REL_FASTER  = 2'h1;
   localparam logic [1:0] REL_NONE    = 2'h2;

   // times in ns, rounded up to cycles
   localparam int CLK_NS          = 5;
   localparam int T28_DEFAULT_NS  = 30;
   localparam int T28_FAST_NS     = 15;
   localparam int T11_DEFAULT_NS  = 40;
   localparam int T11_FAST_NS     = 20;
   localparam int T27_DEFAULT_NS  = 30;
   localparam int T27_FAST_NS     = 15;
   localparam int T28_DEFAULT_CYC = (T28_DEFAULT_NS + CLK_NS - 1) / CLK_NS;
   localparam int T28_FAST_CYC    = (T28_FAST_NS + CLK_NS - 1) / CLK_NS;
   localparam int T11_DEFAULT_CYC = (T11_DEFAULT_NS + CLK_NS - 1) / CLK_NS;
   localparam int T11_FAST_CYC    = (T11_FAST_NS + CLK_NS - 1) / CLK_NS;
   localparam int T27_DEFAULT_CYC = (T27_DEFAULT_NS + CLK_NS - 1) / CLK_NS;
   localparam int T27_FAST_CYC    = (T27_FAST_NS + CLK_NS - 1) / CLK_NS;
   localparam int FILT_LONG_CYC   = 4;
   localparam int FILT_SHORT_CYC  = 2;
endpackage

// ==== logic/vsi_strobe_filter.sv ====
module vsi_strobe_filter
   import vsi_pkg::*;
(
   input  wire logic clk,     // system clock
   input  wire logic rst,     // synchronous reset, high
   input  wire logic pinN,    // raw active-low strobe pin
   input  wire logic filtEn,  // stability filter on
   input  wire logic longSel, // long stability window
   output logic      outN     // cleaned strobe, active low
);
   logic       s1_q;
   logic       s2_q;
   logic       s3_q;
   logic [2:0] cnt_q;
   logic [2:0] need;

   assign need = longSel ? 3'(FILT_LONG_CYC) : 3'(FILT_SHORT_CYC);

   // first stage feeds only the second
   always_ff @(posedge clk) begin
      if (rst) begin
         s1_q <= 1'b1;
         s2_q <= 1'b1;
         s3_q <= 1'b1;
      end else begin
         s1_q <= pinN;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   // stages two and three agree, then the filter window
   always_ff @(posedge clk) begin
      if (rst) begin
         cnt_q <= 3'h0;
         outN  <= 1'b1;
      end else if (s2_q != s3_q || s3_q == outN) begin
         cnt_q <= 3'h0;
      end else if (!filtEn || cnt_q + 3'h2 >= need) begin
         cnt_q <= 3'h0;
         outN  <= s3_q;
      end else begin
         cnt_q <= cnt_q + 3'h1;
      end
   end
endmodule

// ==== tb/vsi_checker.sv ====
module vsi_checker
   import vsi_pkg::*;
(
   input wire logic        clk,                     // clock
   input wire logic        rst,                     // reset
   input wire logic        vmeAsN,                  // address strobe
   input wire logic        vmeDtackOe,              // ack enable
   input wire logic        pciMasterEnable,         // master enable
   input wire logic        pciReq,                  // request
   input wire logic        pciAck,                  // completion
   input wire logic        pciWrite,                // write
   input wire logic [31:0] pciAddr,                 // address
   input wire logic [1:0]  pciSpace,                // space
   input wire logic        pciLock,                 // lock
   input wire logic        pciPosted,               // posted
   input wire logic        pciPrefetch,             // prefetch
   input wire logic [3:0]  masterStrobeHighCycles,  // t11 cycles
   input wire logic [3:0]  masterReadReleaseCycles  // t27 cycles
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk);
   endclocking
   default disable iff (rst);
   sequence posted_start;
      $rose(pciReq) && pciPosted;
   endsequence
   posted_ack_a: assert property (posted_start |-> ##[1:8] vmeDtackOe)
      else $error("posted ack late");
   nonposted_wait_a: assert property ($rose(vmeDtackOe) |-> !pciReq || pciPosted)
      else $error("early ack");
   posted_mem_a: assert property (pciReq && (pciPosted || pciPrefetch) |-> pciSpace == PCI_MEM)
      else $error("posting not to memory");
   req_master_a: assert property ($rose(pciReq) |-> $past(pciMasterEnable))
      else $error("request without enable");
   req_hold_a: assert property (pciReq && !pciAck |=> pciReq)
      else $error("request dropped");
   req_stable_a: assert property (pciReq && $past(pciReq) |-> $stable({pciSpace, pciAddr, pciWrite}))
      else $error("fields changed");
   lock_release_a: assert property ($rose(vmeAsN) |-> ##[1:12] !pciLock)
      else $error("lock kept");
   strobe_time_a: assert property (masterStrobeHighCycles inside {4'(T11_DEFAULT_CYC), 4'(T11_FAST_CYC)})
      else $error("bad strobe time");
   release_time_a: assert property (masterReadReleaseCycles inside {4'(T27_DEFAULT_CYC), 4'(T27_FAST_CYC), 4'h0})
      else $error("bad release time");
endmodule
bind vsi_slave_image vsi_checker vsi_checker_i (
   .clk, .rst, .vmeAsN, .vmeDtackOe, .pciMasterEnable, .pciReq, .pciAck, .pciWrite, .pciAddr, .pciSpace,
   .pciLock, .pciPosted, .pciPrefetch, .masterStrobeHighCycles, .masterReadReleaseCycles
);

// ==== tb/vsi_vme_master.sv ====
module vsi_vme_master
   import vsi_pkg::*;
(
   input  wire logic   clk,         // clock
   input  wire logic   vmeDtackOut, // ack drive level
   input  wire logic   vmeDtackOe,  // ack enable
   output logic        vmeAsN,      // address strobe
   output logic        vmeDs0N,     // data strobe 0
   output logic        vmeDs1N,     // data strobe 1
   output logic        vmeWriteN,   // low for write
   output logic [5:0]  vmeAm,       // modifier
   output logic [31:1] vmeAddr,     // address
   output logic        vmeDtackIn   // ack wire level
);
   timeunit 1ns;
   timeprecision 1ps;
   // pulled up when undriven
   assign vmeDtackIn = vmeDtackOe ? vmeDtackOut : 1'h1;
   initial begin
      vmeAsN = 1'h1;
      vmeDs0N = 1'h1;
      vmeDs1N = 1'h1;
      vmeWriteN = 1'h1;
      vmeAm = 6'h3F;
      vmeAddr = 31'h0;
   end
   task automatic cycle(input logic [31:0] a, input logic [5:0] m, input logic w, output logic ok, output int lat);
      ok = 1'h0;
      lat = 0;
      @(posedge clk);
      vmeAddr <= a[31:1];
      vmeAm <= m;
      vmeWriteN <= ~w;
      @(posedge clk);
      vmeAsN <= 1'h0;
      @(posedge clk);
      vmeDs0N <= 1'h0;
      vmeDs1N <= 1'h0;
      // misses never answer
      while (!ok && lat < 60) begin
         @(posedge clk);
         lat++;
         ok = !vmeDtackIn;
      end
      vmeDs0N <= 1'h1;
      vmeDs1N <= 1'h1;
      vmeAsN <= 1'h1;
      // released lines go invalid
      vmeAddr <= ~a[31:1];
      vmeAm <= ~m;
      repeat (12) @(posedge clk);
   endtask
endmodule

// ==== tb/testbench.sv ====
`define CHK(got, exp) begin nChecks++; if ((got) !== (exp)) begin errTotal++; \
   $display("[FAIL] %0t: got %h exp %h", $time, got, exp); end end
module testbench;
   import vsi_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'h0, rst = 1'h1, hsel = 1'h0, hwrite = 1'h0, pciMasterEnable = 1'h1, pciAck = 1'h0;
   logic holdAck = 1'h0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, pciAddr, snapAddr;
   logic [1:0]  htrans = 2'h0, pciSpace;
   logic [2:0]  hsize = 3'h2, ackCnt = 3'h0;
   logic [3:0]  user1Am = 4'h0, user2Am = 4'h0, masterStrobeHighCycles, masterReadReleaseCycles;
   logic [5:0]  vmeAm;
   logic [6:0]  snap;
   logic [31:1] vmeAddr;
   logic hreadyout, hresp, vmeAsN, vmeDs0N, vmeDs1N, vmeWriteN, vmeDtackIn, vmeDtackOut, vmeDtackOe;
   logic masterDtackN, pciReq, pciWrite, pciWide, pciLock, pciPosted, pciPrefetch;
   int errTotal = 0, nChecks = 0;
   logic [3:0]  rel [3] = '{4'(T27_DEFAULT_CYC), 4'(T27_FAST_CYC), 4'h0};
   logic [31:0] win [4] = '{32'h0001_0000, 32'h0001_FFFE, 32'h0002_0000, 32'h0000_FFFE};
   logic [2:0]  spc [5] = '{SPACE_A16, SPACE_A24, SPACE_A32, SPACE_USER1, SPACE_USER2};
   logic [5:0]  ams [5] = '{6'h29, 6'h39, 6'h09, 6'h13, 6'h1C};
   vsi_slave_image vsi_slave_image_i (.clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
      .hready(hreadyout), .hrdata, .hreadyout, .hresp, .vmeAsN, .vmeDs0N, .vmeDs1N, .vmeWriteN, .vmeAm,
      .vmeAddr, .vmeDtackIn, .vmeDtackOut, .vmeDtackOe, .masterDtackN, .masterStrobeHighCycles,
      .masterReadReleaseCycles, .pciMasterEnable, .user1Am, .user2Am, .pciReq, .pciWrite, .pciAddr,
      .pciSpace, .pciWide, .pciLock, .pciPosted, .pciPrefetch, .pciAck);
   vsi_vme_master vsi_vme_master_i (.clk, .vmeDtackOut, .vmeDtackOe, .vmeAsN, .vmeDs0N, .vmeDs1N,
      .vmeWriteN, .vmeAm, .vmeAddr, .vmeDtackIn);
   always #2.5 clk = ~clk;
   // PCI side acks after three cycles
   always @(posedge clk) begin
      ackCnt <= (pciReq && !holdAck) ? ackCnt + 3'h1 : 3'h0;
      pciAck <= ackCnt == 3'h2;
      if (pciReq) begin
         snap <= {pciSpace, pciPosted, pciPrefetch, pciWide, pciLock, pciWrite};
         snapAddr <= pciAddr;
      end
   end
   task automatic finishTest;
      $display("checks %0d errors %0d", nChecks, errTotal);
      if (errTotal == 0 && nChecks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic rdy;
      int n;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (hreadyout !== 1'h1 && n < 50);
      if (n >= 50) begin
         errTotal++;
         finishTest;
      end
   endtask
   task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
      hsel <= 1'h1;
      haddr <= {20'h0, a};
      hwrite <= w;
      htrans <= 2'h2;
      rdy();
      hsel <= 1'h0;
      htrans <= 2'h0;
      hwdata <= d;
      rdy();
      q = hrdata;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'h1, a, d, q);
   endtask
   task automatic rc(input logic [11:0] a, input logic [31:0] e);
      logic [31:0] q;
      bus(1'h0, a, 32'h0, q);
      `CHK(q, e)
   endtask
   task automatic vme(input logic [31:0] a, input logic [5:0] m, input logic w, input logic e, output int lat);
      logic ok;
      vsi_vme_master_i.cycle(a, m, w, ok, lat);
      `CHK(ok, e)
   endtask
   initial begin
      int lat;
      int la [4];
      repeat (8) @(posedge clk);
      rst <= 1'h0;
      repeat (8) @(posedge clk);
      rc(CONTROL_ADDR, 32'h00F0_0000);
      rc(TUNING_ADDR, 32'h0);
      `CHK(masterReadReleaseCycles, 4'(T27_DEFAULT_CYC))
      wr(TUNING_ADDR, 32'hFFFF_FFFF);
      rc(TUNING_ADDR, 32'h0000_7705);
      for (int i = 0; i < 3; i++) begin
         wr(TUNING_ADDR, (32'(i) << READ_REL_LSB) | (32'(i == 1) << STROBE_HIGH_BIT));
         repeat (3) @(posedge clk);
         `CHK(masterReadReleaseCycles, rel[i])
         `CHK(masterStrobeHighCycles, 4'((i == 1) ? T11_FAST_CYC : T11_DEFAULT_CYC))
      end
      wr(CONTROL_ADDR, 32'hFFFF_FFFF);
      rc(CONTROL_ADDR, 32'hE0F7_00C3);
      wr(BASE_ADDR, 32'hFFFF_FFFF);
      rc(BASE_ADDR, 32'hFFFF_F000);
      wr(12'h800, 32'hFFFF_FFFF);
      rc(12'h800, 32'h0);
      rst <= 1'h1;
      repeat (2) @(posedge clk);
      rst <= 1'h0;
      repeat (8) @(posedge clk);
      rc(CONTROL_ADDR, 32'h00F0_0000);
      rc(BASE_ADDR, 32'h0);
      wr(BASE_ADDR, 32'h0001_0000);
      wr(BOUND_ADDR, 32'h0002_0000);
      wr(CONTROL_ADDR, 32'h80F2_0000);
      for (int i = 0; i < 4; i++) begin
         vme(win[i], 6'h09, 1'h0, i < 2, lat);
      end
      `CHK(snapAddr, win[1])
      pciMasterEnable <= 1'h0;
      vme(win[0], 6'h09, 1'h0, 1'h0, lat);
      pciMasterEnable <= 1'h1;
      wr(CONTROL_ADDR, 32'h00F2_0000);
      vme(win[0], 6'h09, 1'h0, 1'h0, lat);
      `CHK({hresp, masterDtackN}, 2'h1)
      for (int g = 1; g < 4; g++) begin
         for (int v = 1; v < 4; v++) begin
            wr(CONTROL_ADDR, 32'h8002_0000 | (32'(g) << PGM_LSB) | (32'(v) << PRIV_LSB));
            for (int k = 0; k < 4; k++) begin
               vme(win[0], 6'h09 + 6'(k[0] + 4 * k[1]), 1'h0, g[k[0]] & v[k[1]], lat);
            end
         end
      end
      user1Am <= 4'h3;
      user2Am <= 4'hC;
      wr(BASE_ADDR, 32'h0);
      for (int s = 0; s < 5; s++) begin
         wr(CONTROL_ADDR, 32'h80F0_0000 | (32'(spc[s]) << SPACE_LSB));
         for (int j = 0; j < 5; j++) begin
            vme(32'h0000_1000, ams[j], 1'h0, s == j, lat);
         end
      end
      for (int l = 0; l < 3; l++) begin
         wr(CONTROL_ADDR, 32'hE0F2_00C0 | 32'(l));
         vme(win[0], 6'h09, 1'h1, 1'h1, lat);
         `CHK(snap, {2'(l), l == 0, 1'h0, 3'h7})
         vme(win[0], 6'h09, 1'h0, 1'h1, lat);
         `CHK(snap, {2'(l), 1'h0, l == 0, 3'h6})
      end
      wr(CONTROL_ADDR, 32'h80F2_0000);
      vme(win[0], 6'h09, 1'h0, 1'h1, lat);
      `CHK(snap, 7'h00)
      wr(CONTROL_ADDR, 32'hC0F2_0000);
      holdAck <= 1'h1;
      vme(win[0], 6'h09, 1'h1, 1'h1, lat);
      `CHK(pciReq, 1'h1)
      holdAck <= 1'h0;
      repeat (8) @(posedge clk);
      wr(CONTROL_ADDR, 32'h80F2_0000);
      holdAck <= 1'h1;
      vme(win[0], 6'h09, 1'h1, 1'h0, lat);
      holdAck <= 1'h0;
      repeat (8) @(posedge clk);
      wr(CONTROL_ADDR, 32'hE0F2_0000);
      for (int f = 0; f < 2; f++) begin
         wr(TUNING_ADDR, (32'(f) << POSTED_ACK_BIT) | (32'(f) << PREFETCH_ACK_BIT));
         vme(win[0], 6'h09, 1'h1, 1'h1, la[f]);
         vme(win[0], 6'h09, 1'h0, 1'h1, la[f + 2]);
      end
      `CHK(la[0] - la[1], T28_DEFAULT_CYC - T28_FAST_CYC)
      `CHK(la[2] - la[3], T28_DEFAULT_CYC - T28_FAST_CYC)
      for (int b = 0; b < 2; b++) begin
         wr(TUNING_ADDR, 32'h1 << (b ? DS_FILT_BIT : AS_FILT_BIT));
         vme(win[0], 6'h09, 1'h1, 1'h1, lat);
         `CHK(lat > la[0], 1'h1)
      end
      finishTest;
   end
endmodule
